// *** common/vbit_pkg.sv ***
package vbit_pkg;
	// Register byte offsets on the APB slave.
	localparam logic [11:0] OFS_FIELD1 = 12'h000;
	localparam logic [11:0] OFS_FIELD2 = 12'h004;
	localparam logic [11:0] OFS_CTRL   = 12'h008;
	localparam logic [11:0] OFS_HEIGHT = 12'h00C;
	localparam logic [11:0] OFS_STATUS = 12'h010;
	localparam logic [11:0] OFS_LUMA_A = 12'h020;
	localparam logic [11:0] OFS_BLUE   = 12'h024;
	localparam logic [11:0] OFS_RED    = 12'h028;
	localparam logic [11:0] OFS_LUMA_B = 12'h02C;

	// Field layout of both blanking flag line registers.
	localparam int LINE_W  = 12;
	localparam int CLR_LSB = 16;
	localparam int SET_LSB = 0;
	localparam logic [11:0] LINE_RST = 12'h000;

	// Control and status bit positions.
	localparam int CTRL_EN      = 0;
	localparam int CTRL_RAW     = 1;
	localparam int STAT_VFLAG   = 0;
	localparam int STAT_DMA     = 1;
	localparam int STAT_OVF     = 2;
	localparam int STAT_CNT_LSB = 16;

	localparam logic [11:0] HEIGHT_RST = 12'h20D;
	localparam logic [11:0] FIRST_LINE = 12'h001;

	// Line timing in pixel clocks.
	localparam int LINE_CYCLES_DEF   = 858;
	localparam int ACTIVE_CYCLES_DEF = 720;

	// Channel numbering of the display FIFOs.
	localparam int CH_LUMA = 0;
	localparam int CH_BLUE = 1;
	localparam int CH_RED  = 2;
	localparam int NUM_CH  = 3;
endpackage : vbit_pkg

// *** common/fifo_port_if.sv ***
`timescale 1ns/1ps
interface fifo_port_if #(
	parameter int DW = 32,
	parameter int AW = 4
);
	logic          push;
	logic [DW-1:0] wdata;
	logic          pop;
	logic [DW-1:0] rdata;
	logic [AW:0]   level;
	logic          full;
	logic          empty;

	modport store (input push, input wdata, input pop,
		output rdata, output level, output full, output empty);
	modport user (output push, output wdata, output pop,
		input rdata, input level, input full, input empty);
endinterface : fifo_port_if

// *** logic/display_fifo_mem.sv ***
`timescale 1ns/1ps
module display_fifo_mem #(
	parameter int DW = 32,
	parameter int AW = 4
)(
	input wire logic   clk,   // Pixel clock.
	input wire logic   rst_b, // Asynchronous reset, active low.
	fifo_port_if.store port   // Push, pop and status.
);
	logic [DW-1:0] mem [2**AW];
	logic [AW:0]   wrPtr;
	logic [AW:0]   rdPtr;
	logic [DW-1:0] rdWord;
	logic [AW:0]   next_wrPtr;
	logic [AW:0]   next_rdPtr;
	logic [DW-1:0] next_rdWord;
	logic          doPush;
	logic          doPop;

	assign port.level = wrPtr - rdPtr;
	assign port.full  = (port.level == (AW+1)'(2**AW));
	assign port.empty = (wrPtr == rdPtr);
	assign port.rdata = rdWord;

	always_comb
	begin
		// A push into a full store is dropped; the owner flags it.
		doPush      = port.push && !port.full;
		doPop       = port.pop && !port.empty;
		next_wrPtr  = doPush ? wrPtr + (AW+1)'(1) : wrPtr;
		next_rdPtr  = doPop ? rdPtr + (AW+1)'(1) : rdPtr;
		next_rdWord = doPop ? mem[rdPtr[AW-1:0]] : rdWord;
	end

	always_ff @(posedge clk)
	begin
		if (doPush)
		begin
			mem[wrPtr[AW-1:0]] <= port.wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wrPtr  <= '0;
			rdPtr  <= '0;
			rdWord <= '0;
		end
		else
		begin
			wrPtr  <= next_wrPtr;
			rdPtr  <= next_rdPtr;
			rdWord <= next_rdWord;
		end
	end
endmodule : display_fifo_mem

// *** logic/display_vbit_and_fifo_map.sv ***
// Function
// - At line start outside raw mode, V goes to 1 when line counter equals field-1 start line.
// - V holds 1 until the line start where counter equals field-1 clear line.
// - V comes only from line comparisons, never from the blanking output signal.
// - Field DMA requests begin only once the line counter has reached 1.
// - At line start outside raw mode, V goes to 1 when line counter equals field-2 start line.
// - V holds 1 until the line start where counter equals field-2 clear line.
// - Field-1 register: clear line 27:16, start line 11:0, reserved read zero.
// - Field-2 register has the same layout and reserved behaviour.
// - Normal modes: three channels fill luma, blue, red FIFOs on own requests.
// - Raw mode: only the luma channel and request are used.
// - Both luma destinations A and B feed the luma FIFO, also in raw mode.
// - Destination reads return zero and leave the FIFOs untouched.
`timescale 1ns/1ps
module display_vbit_and_fifo_map #(
	parameter int LINE_CYCLES   = vbit_pkg::LINE_CYCLES_DEF,
	parameter int ACTIVE_CYCLES = vbit_pkg::ACTIVE_CYCLES_DEF,
	parameter int FIFO_AW       = 4,
	parameter int REQ_LEVEL     = 8
)(
	input wire logic         clk,              // Pixel clock, 125 MHz.
	input wire logic         rst_b,            // Asynchronous reset, active low.
	input wire logic         psel,             // APB select.
	input wire logic         penable,          // APB access phase.
	input wire logic         pwrite,           // APB write.
	input wire logic [11:0]  paddr,            // APB byte address.
	input wire logic [31:0]  pwdata,           // APB write data.
	output logic [31:0]      prdata,           // APB read data.
	output logic             pready,           // APB ready.
	output logic             pslverr,          // APB error on unmapped address.
	output logic             eavPulse,         // Timing code at line start.
	output logic             vFlag,            // V bit of the timing codes.
	output logic [11:0]      frameLineCounter, // Current frame line.
	output logic             activeVideo,      // Active part of the line.
	output logic             lumaReq,          // Luma FIFO request pulse.
	output logic             blueReq,          // Blue difference request pulse.
	output logic             redReq,           // Red difference request pulse.
	output logic [31:0]      lumaWord,         // Last luma word popped.
	output logic [31:0]      blueWord,         // Last blue word popped.
	output logic [31:0]      redWord           // Last red word popped.
);
	localparam int PW = $clog2(LINE_CYCLES + 1);
	localparam int NC = vbit_pkg::NUM_CH;

	logic [11:0]   f1Clr;
	logic [11:0]   f1Set;
	logic [11:0]   f2Clr;
	logic [11:0]   f2Set;
	logic          enable;
	logic          rawMode;
	logic [11:0]   frameHeight;
	logic          overflow;
	logic [11:0]   next_f1Clr;
	logic [11:0]   next_f1Set;
	logic [11:0]   next_f2Clr;
	logic [11:0]   next_f2Set;
	logic          next_enable;
	logic          next_rawMode;
	logic [11:0]   next_frameHeight;
	logic          next_overflow;
	logic [31:0]   next_prdata;
	logic          next_pready;
	logic          next_pslverr;
	logic          access;
	logic          wrEn;
	logic          setup;
	logic [11:0]   wrClr;
	logic [11:0]   wrSet;

	logic [PW-1:0] pixelCount;
	logic          dmaStarted;
	logic [PW-1:0] next_pixelCount;
	logic [11:0]   next_lineCount;
	logic          next_vFlag;
	logic          next_dmaStarted;
	logic          next_eavPulse;
	logic          next_active;
	logic          lineStart;

	logic [NC-1:0] push;
	logic [NC-1:0] pop;
	logic [NC-1:0] full;
	logic [NC-1:0] empty;
	logic [NC-1:0] used;
	logic [NC-1:0] req;
	logic [NC-1:0] pending;
	logic [NC-1:0] next_req;
	logic [NC-1:0] next_pending;
	logic [FIFO_AW:0] level [NC];
	logic [31:0]   rdWord [NC];

	// One-hot channel of a destination address; both luma slots share one FIFO.
	function automatic logic [NC-1:0] destChannel(input logic [11:0] addr);
		logic [NC-1:0] ch;
		ch[vbit_pkg::CH_LUMA] = addr == vbit_pkg::OFS_LUMA_A || addr == vbit_pkg::OFS_LUMA_B;
		ch[vbit_pkg::CH_BLUE] = addr == vbit_pkg::OFS_BLUE;
		ch[vbit_pkg::CH_RED]  = addr == vbit_pkg::OFS_RED;
		return ch;
	endfunction : destChannel

	function automatic logic isControl(input logic [11:0] addr);
		return addr == vbit_pkg::OFS_FIELD1 || addr == vbit_pkg::OFS_FIELD2 ||
			addr == vbit_pkg::OFS_CTRL || addr == vbit_pkg::OFS_HEIGHT ||
			addr == vbit_pkg::OFS_STATUS;
	endfunction : isControl

	fifo_port_if #(.DW(32), .AW(FIFO_AW)) chan[NC] ();

	generate
		for (genvar i = 0; i < NC; i++)
		begin : g_chan
			assign chan[i].push  = push[i];
			assign chan[i].wdata = pwdata;
			assign chan[i].pop   = pop[i];
			assign level[i]      = chan[i].level;
			assign full[i]       = chan[i].full;
			assign empty[i]      = chan[i].empty;
			assign rdWord[i]     = chan[i].rdata;
			display_fifo_mem #(.DW(32), .AW(FIFO_AW)) u_fifo (
				.clk   (clk),
				.rst_b (rst_b),
				.port  (chan[i].store)
			);
		end
	endgenerate

	assign lumaWord = rdWord[vbit_pkg::CH_LUMA];
	assign blueWord = rdWord[vbit_pkg::CH_BLUE];
	assign redWord  = rdWord[vbit_pkg::CH_RED];
	assign lumaReq  = req[vbit_pkg::CH_LUMA];
	assign blueReq  = req[vbit_pkg::CH_BLUE];
	assign redReq   = req[vbit_pkg::CH_RED];

	// Chroma FIFOs take no part in raw mode.
	assign used = {!rawMode, !rawMode, 1'b1};

	always_comb
	begin
		setup            = psel && !penable;
		access           = psel && penable && pready;
		wrEn             = access && pwrite;
		wrClr            = pwdata[vbit_pkg::CLR_LSB +: vbit_pkg::LINE_W];
		wrSet            = pwdata[vbit_pkg::SET_LSB +: vbit_pkg::LINE_W];
		next_pready      = setup;
		next_pslverr     = setup && !isControl(paddr) && destChannel(paddr) == '0;
		next_prdata      = setup ? 32'h0000_0000 : prdata;
		next_f1Clr       = f1Clr;
		next_f1Set       = f1Set;
		next_f2Clr       = f2Clr;
		next_f2Set       = f2Set;
		next_enable      = enable;
		next_rawMode     = rawMode;
		next_frameHeight = frameHeight;
		// Destinations push only on a write; a read returns zero.
		push = (wrEn ? destChannel(paddr) : '0) & used;
		if (setup && !pwrite)
		begin
			unique case (paddr)
				vbit_pkg::OFS_FIELD1: next_prdata = {4'h0, f1Clr, 4'h0, f1Set};
				vbit_pkg::OFS_FIELD2: next_prdata = {4'h0, f2Clr, 4'h0, f2Set};
				vbit_pkg::OFS_CTRL:   next_prdata = {30'h0000_0000, rawMode, enable};
				vbit_pkg::OFS_HEIGHT: next_prdata = {20'h0_0000, frameHeight};
				vbit_pkg::OFS_STATUS: next_prdata = {4'h0, frameLineCounter, 13'h0000,
					overflow, dmaStarted, vFlag};
				default:              next_prdata = 32'h0000_0000;
			endcase
		end
		if (wrEn)
		begin
			unique case (paddr)
				vbit_pkg::OFS_FIELD1: {next_f1Clr, next_f1Set} = {wrClr, wrSet};
				vbit_pkg::OFS_FIELD2: {next_f2Clr, next_f2Set} = {wrClr, wrSet};
				vbit_pkg::OFS_CTRL:
				begin
					next_enable  = pwdata[vbit_pkg::CTRL_EN];
					next_rawMode = pwdata[vbit_pkg::CTRL_RAW];
				end
				vbit_pkg::OFS_HEIGHT: next_frameHeight = pwdata[11:0];
				default:              next_frameHeight = frameHeight;
			endcase
		end
		// A drop in the same cycle as the clear keeps the flag set.
		next_overflow = (|(push & full)) || (overflow && !(wrEn &&
			paddr == vbit_pkg::OFS_STATUS && pwdata[vbit_pkg::STAT_OVF]));
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prdata      <= 32'h0000_0000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			f1Clr       <= vbit_pkg::LINE_RST;
			f1Set       <= vbit_pkg::LINE_RST;
			f2Clr       <= vbit_pkg::LINE_RST;
			f2Set       <= vbit_pkg::LINE_RST;
			enable      <= 1'b0;
			rawMode     <= 1'b0;
			frameHeight <= vbit_pkg::HEIGHT_RST;
			overflow    <= 1'b0;
		end
		else
		begin
			prdata      <= next_prdata;
			pready      <= next_pready;
			pslverr     <= next_pslverr;
			f1Clr       <= next_f1Clr;
			f1Set       <= next_f1Set;
			f2Clr       <= next_f2Clr;
			f2Set       <= next_f2Set;
			enable      <= next_enable;
			rawMode     <= next_rawMode;
			frameHeight <= next_frameHeight;
			overflow    <= next_overflow;
		end
	end

	always_comb
	begin
		lineStart       = enable && pixelCount == '0;
		next_pixelCount = (!enable || pixelCount == PW'(LINE_CYCLES - 1)) ? '0 : pixelCount + PW'(1);
		next_lineCount  = enable ? frameLineCounter : 12'h000;
		if (lineStart)
		begin
			// Counter at zero means the first line after enable.
			next_lineCount = (frameLineCounter == '0 || frameLineCounter >= frameHeight) ?
				vbit_pkg::FIRST_LINE : frameLineCounter + 12'h001;
		end
		// The V bit looks only at line numbers; no blanking signal enters here.
		next_vFlag = vFlag && enable && !rawMode;
		if (lineStart && !rawMode)
		begin
			if (next_lineCount == f1Set || next_lineCount == f2Set)
			begin
				next_vFlag = 1'b1;
			end
			else if (next_lineCount == f1Clr || next_lineCount == f2Clr)
			begin
				next_vFlag = 1'b0;
			end
		end
		next_dmaStarted = enable && (dmaStarted ||
			(lineStart && next_lineCount == vbit_pkg::FIRST_LINE));
		next_eavPulse = lineStart;
		next_active   = enable && pixelCount < PW'(ACTIVE_CYCLES);
		// Each word carries four samples, so the encoder drains one luma word per four clocks and one blue or red word per eight.
		pop[vbit_pkg::CH_LUMA] = next_active && pixelCount[1:0] == 2'h0;
		pop[vbit_pkg::CH_BLUE] = next_active && !rawMode && pixelCount[2:0] == 3'h0;
		pop[vbit_pkg::CH_RED]  = next_active && !rawMode && pixelCount[2:0] == 3'h4;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pixelCount       <= '0;
			frameLineCounter <= 12'h000;
			vFlag            <= 1'b0;
			dmaStarted       <= 1'b0;
			eavPulse         <= 1'b0;
			activeVideo      <= 1'b0;
		end
		else
		begin
			pixelCount       <= next_pixelCount;
			frameLineCounter <= next_lineCount;
			vFlag            <= next_vFlag;
			dmaStarted       <= next_dmaStarted;
			eavPulse         <= next_eavPulse;
			activeVideo      <= next_active;
		end
	end

	always_comb
	begin
		// One request per low-water episode; the next push re-arms the channel.
		for (int i = 0; i < NC; i++)
		begin
			next_req[i] = dmaStarted && used[i] && !pending[i] && !push[i] &&
				level[i] < (FIFO_AW+1)'(REQ_LEVEL);
			next_pending[i] = dmaStarted && used[i] && (next_req[i] ||
				(pending[i] && !push[i]));
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			req     <= '0;
			pending <= '0;
		end
		else
		begin
			req     <= next_req;
			pending <= next_pending;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	a_vflag_set1: assert property (lineStart && !rawMode && next_lineCount == f1Set |=> vFlag)
		else $error("V flag not set at field 1 start line");
	a_vflag_clr1: assert property (lineStart && !rawMode && next_lineCount == f1Clr &&
		next_lineCount != f1Set && next_lineCount != f2Set |=> !vFlag)
		else $error("V flag not cleared at field 1 clear line");
	a_vflag_set2: assert property (lineStart && !rawMode && next_lineCount == f2Set |=> vFlag)
		else $error("V flag not set at field 2 start line");
	a_vflag_clr2: assert property (lineStart && !rawMode && next_lineCount == f2Clr &&
		next_lineCount != f1Set && next_lineCount != f2Set |=> !vFlag)
		else $error("V flag not cleared at field 2 clear line");
	a_vflag_hold: assert property (enable && !rawMode && !lineStart |=> $stable(vFlag))
		else $error("V flag changed away from a line start");
	a_dma_gate: assert property (!dmaStarted |=> req == '0 ##1 (dmaStarted || req == '0))
		else $error("DMA request before the first line");
	a_raw_chroma: assert property (rawMode |-> push[vbit_pkg::CH_BLUE] == 1'b0 &&
		push[vbit_pkg::CH_RED] == 1'b0 ##1 (!rawMode || !blueReq && !redReq))
		else $error("Chroma channel active in raw mode");
	a_dest_read: assert property (access && !pwrite |-> push == '0)
		else $error("Destination read disturbed a FIFO");
	a_line_wrap: assert property (lineStart && frameLineCounter == frameHeight &&
		frameLineCounter != '0 |=> frameLineCounter == vbit_pkg::FIRST_LINE)
		else $error("Line counter did not wrap to one");
	a_reserved_zero: assert property (access && !pwrite &&
		(paddr == vbit_pkg::OFS_FIELD1 || paddr == vbit_pkg::OFS_FIELD2) |->
		prdata[31:28] == 4'h0 && prdata[15:12] == 4'h0)
		else $error("Reserved bits read nonzero");

	c_vflag_rise: cover property (!vFlag ##1 vFlag);
	c_luma_req: cover property (lumaReq ##[1:50] push[vbit_pkg::CH_LUMA]);
	c_frame_wrap: cover property (lineStart && next_lineCount == vbit_pkg::FIRST_LINE &&
		frameLineCounter != '0);
endmodule : display_vbit_and_fifo_map

// *** tb/video_encoder_model.sv ***
`timescale 1ns/1ps
module video_encoder_model (
	input wire logic        clk,       // Pixel clock.
	input wire logic        rst_b,     // Reset, active low.
	input wire logic        eavPulse,  // Timing code strobe.
	input wire logic        vFlag,     // V bit beside the code.
	input wire logic [11:0] lineNum,   // Line carried with the code.
	output logic            codeV,     // V bit of the last code.
	output logic [11:0]     codeLine,  // Line of the last code.
	output logic [15:0]     codeCount  // Timing codes received.
);
	// The encoder reads V only inside a timing code, so no blanking strobe is looked at.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			codeV     <= 1'b0;
			codeLine  <= 12'h000;
			codeCount <= 16'h0000;
		end
		else if (eavPulse)
		begin
			codeV     <= vFlag;
			codeLine  <= lineNum;
			codeCount <= codeCount + 16'h0001;
		end
	end
endmodule : video_encoder_model

// *** tb/tb_display_vbit_and_fifo_map.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin numErrors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_display_vbit_and_fifo_map;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        eavPulse;
	logic        vFlag;
	logic [11:0] frameLineCounter;
	logic        activeVideo;
	logic        lumaReq;
	logic        blueReq;
	logic        redReq;
	logic [31:0] lumaWord;
	logic [31:0] blueWord;
	logic [31:0] redWord;
	logic        codeV;
	logic [11:0] codeLine;
	logic [15:0] codeCount;
	int          numErrors = 0;
	int          numChecks = 0;
	int          lumaReqs = 0;
	int          blueReqs = 0;
	int          redReqs = 0;
	int          actCycles = 0;

	always #4 clk = ~clk;

	display_vbit_and_fifo_map #(.LINE_CYCLES(20), .ACTIVE_CYCLES(12)) u_display_vbit_and_fifo_map (
		.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .eavPulse(eavPulse), .vFlag(vFlag),
		.frameLineCounter(frameLineCounter), .activeVideo(activeVideo),
		.lumaReq(lumaReq), .blueReq(blueReq), .redReq(redReq),
		.lumaWord(lumaWord), .blueWord(blueWord), .redWord(redWord));

	video_encoder_model u_video_encoder_model (
		.clk(clk), .rst_b(rst_b), .eavPulse(eavPulse), .vFlag(vFlag),
		.lineNum(frameLineCounter), .codeV(codeV), .codeLine(codeLine),
		.codeCount(codeCount));

	always @(posedge clk)
	begin
		if (lumaReq === 1'b1) lumaReqs <= lumaReqs + 1;
		if (blueReq === 1'b1) blueReqs <= blueReqs + 1;
		if (redReq === 1'b1) redReqs <= redReqs + 1;
		if (activeVideo === 1'b1) actCycles <= actCycles + 1;
	end

	task automatic printVerdict();
		if (numErrors == 0 && numChecks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : printVerdict

	// The master waits on pready itself; the answer latency is never assumed.
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdat,
		output logic [31:0] rdat, output logic err);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wdat;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rdat = prdata;
		err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] addr, input logic [31:0] wdat);
		logic [31:0] d;
		logic        e;
		apb(1'b1, addr, wdat, d, e);
		`CHK(e, 1'b0)
	endtask : wr

	task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp, input logic expErr);
		logic [31:0] d;
		logic        e;
		apb(1'b0, addr, 32'h0000_0000, d, e);
		`CHK(e, expErr)
		`CHK(d, exp)
	endtask : rdchk

	task automatic waitCode();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (eavPulse !== 1'b1 && n < 200);
		if (n >= 200) numErrors++;
		#1;
	endtask : waitCode

	task automatic testReset();
		`CHK(vFlag, 1'b0)
		`CHK(frameLineCounter, 12'h000)
		rdchk(vbit_pkg::OFS_FIELD1, 32'h0000_0000, 1'b0);
		rdchk(vbit_pkg::OFS_FIELD2, 32'h0000_0000, 1'b0);
		rdchk(vbit_pkg::OFS_STATUS, 32'h0000_0000, 1'b0);
	endtask : testReset

	task automatic testFields();
		wr(vbit_pkg::OFS_FIELD1, 32'hFFFF_FFFF);
		rdchk(vbit_pkg::OFS_FIELD1, 32'h0FFF_0FFF, 1'b0);
		wr(vbit_pkg::OFS_FIELD2, 32'hF5A5_A5A5);
		rdchk(vbit_pkg::OFS_FIELD2, 32'h05A5_05A5, 1'b0);
		rdchk(12'h030, 32'h0000_0000, 1'b1);
	endtask : testFields

	// Field 1 blanks lines 10 to 2 across the wrap, so line 1 falls inside it.
	task automatic testStream();
		logic [11:0] line;
		logic        v;
		int          a;
		a    = 0;
		line = 12'h000;
		v    = 1'b0;
		wr(vbit_pkg::OFS_HEIGHT, 32'h0000_000A);
		wr(vbit_pkg::OFS_FIELD1, 32'h0003_000A);
		wr(vbit_pkg::OFS_FIELD2, 32'h0007_0005);
		wr(vbit_pkg::OFS_LUMA_A, 32'h1111_1111);
		rdchk(vbit_pkg::OFS_LUMA_A, 32'h0000_0000, 1'b0);
		wr(vbit_pkg::OFS_LUMA_B, 32'h2222_2222);
		wr(vbit_pkg::OFS_BLUE, 32'h3333_3333);
		wr(vbit_pkg::OFS_RED, 32'h4444_4444);
		wr(vbit_pkg::OFS_CTRL, 32'h0000_0001);
		for (int i = 0; i < 22; i++)
		begin
			waitCode();
			if (i == 0) `CHK(lumaReqs, 0)
			if (i == 1) a = actCycles;
			if (i == 2) `CHK(actCycles - a, 12)
			line = (line >= 12'h00A) ? 12'h001 : line + 12'h001;
			if (line == 12'h00A || line == 12'h005) v = 1'b1;
			else if (line == 12'h003 || line == 12'h007) v = 1'b0;
			`CHK(codeLine, line)
			`CHK(codeV, v)
		end
		`CHK(lumaReqs > 0, 1'b1)
		`CHK(blueReqs > 0 && redReqs > 0, 1'b1)
		`CHK(lumaWord, 32'h2222_2222)
		`CHK(blueWord, 32'h3333_3333)
		`CHK(redWord, 32'h4444_4444)
	endtask : testStream

	// Progressive output: the field-2 lines sit above the frame height and never match.
	task automatic testProgressive();
		logic [11:0] line;
		logic        v;
		line = 12'h000;
		v    = 1'b0;
		wr(vbit_pkg::OFS_CTRL, 32'h0000_0000);
		wr(vbit_pkg::OFS_FIELD2, 32'h011B_0108);
		wr(vbit_pkg::OFS_CTRL, 32'h0000_0001);
		for (int i = 0; i < 12; i++)
		begin
			waitCode();
			line = (line >= 12'h00A) ? 12'h001 : line + 12'h001;
			if (line == 12'h00A) v = 1'b1;
			else if (line == 12'h003) v = 1'b0;
			`CHK(codeLine, line)
			`CHK(codeV, v)
		end
	endtask : testProgressive

	task automatic testRaw();
		int b;
		wr(vbit_pkg::OFS_CTRL, 32'h0000_0002);
		// The counter clears one edge after the disable has landed.
		repeat (2) @(posedge clk);
		#1;
		`CHK(frameLineCounter, 12'h000)
		b = blueReqs;
		wr(vbit_pkg::OFS_BLUE, 32'h5555_5555);
		wr(vbit_pkg::OFS_LUMA_A, 32'h6666_6666);
		wr(vbit_pkg::OFS_CTRL, 32'h0000_0003);
		for (int i = 0; i < 12; i++)
		begin
			waitCode();
			`CHK(codeV, 1'b0)
		end
		`CHK(lumaWord, 32'h6666_6666)
		`CHK(blueWord, 32'h3333_3333)
		`CHK(blueReqs, b)
		// Back in normal mode a word stored in raw mode would now be popped.
		wr(vbit_pkg::OFS_CTRL, 32'h0000_0001);
		repeat (2) waitCode();
		`CHK(blueWord, 32'h3333_3333)
	endtask : testRaw

	initial
	begin
		repeat (20000) @(posedge clk);
		numErrors++;
		printVerdict();
	end

	initial
	begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		#1;
		testReset();
		testFields();
		testStream();
		testProgressive();
		testRaw();
		printVerdict();
	end
endmodule : tb_display_vbit_and_fifo_map
